// ==== sim/fpsc_top_tb.sv ====
module fpsc_top_tb import fpsc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Signals and design
  // ****************************************
  logic clk = 1'h0;
  logic rst, psel, penable, pwrite, sleep_mode, fc_wr_req, pready, pslverr, err;
  logic fc_wr_block, flash_supply_on, code_protect_on;
  logic [15:0] paddr, fc_wr_addr;
  logic [31:0] pwdata, prdata, rd;
  logic [23:0] zone_bits;
  logic [3:0] info_bits;
  int failures = 0;
  int compares = 0;
  int n;
  // Short delay keeps the unlock wait to about twenty cycles
  fpsc_top #(.DELAY_CYCLES(20)) i_fpsc_top (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sleep_mode(sleep_mode), .fc_wr_req(fc_wr_req), .fc_wr_addr(fc_wr_addr), .fc_wr_block(fc_wr_block),
    .flash_supply_on(flash_supply_on), .zone_permanent_protect_bits(zone_bits),
    .info_block_protect_bits(info_bits), .code_protect_on(code_protect_on));
  // 100 MHz clock
  always #5 clk = ~clk;
  // ****************************************
  // Tasks
  // ****************************************
  // Compare and count
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer; bounded wait so a dead slave cannot hang us
  task apb(input logic w, input logic [15:0] a, input logic [7:0] d);
    int k;
    @(posedge clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'h1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'h1 && k < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (k == 20) failures++;
  endtask
  // Protected write: key pair first, nothing in between
  task twr(input logic [15:0] a, input logic [7:0] d);
    apb(1'h1, ADDR_TA_KEY, TA_KEY1);
    apb(1'h1, ADDR_TA_KEY, TA_KEY2);
    apb(1'h1, a, d);
  endtask
  // Edges until protection drops
  task rel_wait;
    n = 0;
    while (code_protect_on !== 1'h0 && n < 100) begin
      @(posedge clk);
      n++;
    end
  endtask
  task complete_run;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ****************************************
  // Tests
  // ****************************************
  // Watchdog well past the expected few hundred cycles
  initial begin
    #50000;
    failures++;
    complete_run;
  end
  initial begin
    rst = 1'h1;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 16'h0;
    pwdata = 32'h0;
    sleep_mode = 1'h1;
    fc_wr_req = 1'h1;
    fc_wr_addr = 16'hffff;
    repeat (8) @(posedge clk);
    rst <= 1'h0;
    repeat (2) @(posedge clk);
    // Reset state
    chk(code_protect_on, 32'h1);
    chk(fc_wr_block, 32'h1);
    chk(flash_supply_on, 32'h1);
    chk(zone_bits, 32'hffffff);
    chk(info_bits, 32'hc);
    apb(1'h0, ADDR_INFO_PROT, 8'h0);
    chk(rd, {24'h0, INFO_RESET});
    chk(err, 32'h0);
    for (int i = 0; i < 3; i++) begin
      apb(1'h0, ADDR_ZONE5 + 16'(i), 8'h0);
      chk(rd, 32'hff);
    end
    apb(1'h0, ADDR_CODE_UNLOCK, 8'h0);
    chk(rd[STAT_BIT], 32'h0);
    $display("test reset done");
    // Writes without the key pair must not land
    apb(1'h1, ADDR_ZONE5, 8'h00);
    apb(1'h1, ADDR_ZONE6, 8'h00);
    apb(1'h1, ADDR_CODE_UNLOCK, UNLOCK_VALUE);
    apb(1'h1, ADDR_SUPPLY_SWITCH, ARM_VALUE);
    repeat (30) @(posedge clk);
    chk(zone_bits, 32'hffffff);
    chk(code_protect_on, 32'h1);
    chk(flash_supply_on, 32'h1);
    $display("test unkeyed done");
    // Zone and info bytes
    for (int i = 0; i < 3; i++) twr(ADDR_ZONE5 + 16'(i), 8'h5a ^ 8'(i));
    for (int i = 0; i < 3; i++) begin
      apb(1'h0, ADDR_ZONE5 + 16'(i), 8'h0);
      chk(rd, 32'h5a ^ i);
    end
    chk(zone_bits, 32'h585b5a);
    twr(ADDR_INFO_PROT, 8'hff);
    apb(1'h0, ADDR_INFO_PROT, 8'h0);
    chk(rd, {24'h0, INFO_MASK});
    chk(info_bits, 32'hf);
    twr(ADDR_INFO_PROT, 8'h21);
    apb(1'h0, ADDR_INFO_PROT, 8'h0);
    chk(rd, 32'h21);
    chk(info_bits, 32'h9);
    fc_wr_req <= 1'h0;
    repeat (2) @(posedge clk);
    chk(fc_wr_block, 32'h0);
    fc_wr_req <= 1'h1;
    $display("test zones done");
    // Unlock after the delay, then any other value re-protects
    twr(ADDR_CODE_UNLOCK, UNLOCK_VALUE);
    rel_wait;
    chk(n >= 20 && n <= 25, 32'h1);
    apb(1'h0, ADDR_CODE_UNLOCK, 8'h0);
    chk(rd[STAT_BIT], 32'h1);
    chk(fc_wr_block, 32'h0);
    twr(ADDR_CODE_UNLOCK, 8'h00);
    repeat (2) @(posedge clk);
    chk(code_protect_on, 32'h1);
    chk(fc_wr_block, 32'h1);
    // Pending unlock abandoned by a wrong value
    twr(ADDR_CODE_UNLOCK, UNLOCK_VALUE);
    twr(ADDR_CODE_UNLOCK, 8'haa);
    repeat (40) @(posedge clk);
    chk(code_protect_on, 32'h1);
    // Rewrite mid-delay restarts the count
    twr(ADDR_CODE_UNLOCK, UNLOCK_VALUE);
    apb(1'h0, ADDR_CODE_UNLOCK, 8'h0);
    chk(rd[STAT_BIT], 32'h0);
    twr(ADDR_CODE_UNLOCK, UNLOCK_VALUE);
    rel_wait;
    chk(n >= 20 && n <= 25, 32'h1);
    $display("test unlock done");
    // Sleep supply switch
    chk(flash_supply_on, 32'h1);
    twr(ADDR_SUPPLY_SWITCH, ARM_VALUE);
    repeat (2) @(posedge clk);
    chk(flash_supply_on, 32'h0);
    apb(1'h0, ADDR_SLEEP_CTL, 8'h0);
    chk(rd[0], 32'h1);
    sleep_mode <= 1'h0;
    repeat (2) @(posedge clk);
    chk(flash_supply_on, 32'h1);
    $display("test supply done");
    // Unmapped address
    apb(1'h0, 16'ha000, 8'h0);
    chk(err, 32'h1);
    chk(rd, 32'h0);
    $display("test unmapped done");
    // Reset in mid-run while released and armed
    sleep_mode <= 1'h1;
    rst <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    chk(code_protect_on, 32'h1);
    chk(zone_bits, 32'hffffff);
    chk(flash_supply_on, 32'h1);
    apb(1'h0, ADDR_SLEEP_CTL, 8'h0);
    chk(rd[0], 32'h0);
    $display("test rereset done");
    complete_run;
  end
endmodule // fpsc_top_tb

// ==== verilog/fpsc_delay_timer.sv ====
module fpsc_delay_timer import fpsc_pkg::*; #(
  parameter int DELAY_CYCLES = UNLOCK_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic cancel,
  output logic running,
  output logic done
);
  logic [CNT_W-1:0] count, next_count;
  logic next_running, next_done;
  localparam logic [CNT_W-1:0] LAST = CNT_W'(DELAY_CYCLES - 1);
  // Restart from zero on every start; cancel beats expiry
  always_comb begin
    next_count = count;
    next_running = running;
    next_done = 1'b0;
    if (cancel) begin
      next_running = 1'b0;
      next_count = '0;
    end else if (start) begin
      next_running = 1'b1;
      next_count = '0;
    end else if (running) begin
      if (count == LAST) begin
        next_running = 1'b0;
        next_done = 1'b1;
      end else begin
        next_count = count + 1'b1;
      end
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= '0;
      running <= 1'b0;
      done <= 1'b0;
    end else begin
      count <= next_count;
      running <= next_running;
      done <= next_done;
    end
  end
endmodule // fpsc_delay_timer

// ==== verilog/fpsc_pkg.sv ====
package fpsc_pkg;
  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [15:0] ADDR_SUPPLY_SWITCH = 16'ha015;
  localparam logic [15:0] ADDR_CODE_UNLOCK = 16'ha027;
  localparam logic [15:0] ADDR_ZONE5 = 16'ha0c5;
  localparam logic [15:0] ADDR_ZONE6 = 16'ha0c6;
  localparam logic [15:0] ADDR_ZONE7 = 16'ha0c7;
  localparam logic [15:0] ADDR_INFO_PROT = 16'ha0c8;
  localparam logic [15:0] ADDR_TA_KEY = 16'ha0f0;
  localparam logic [15:0] ADDR_SLEEP_CTL = 16'ha0f4;
  // ****************************************
  // Values and fields
  // ****************************************
  localparam logic [7:0] UNLOCK_VALUE = 8'h55;
  localparam logic [7:0] ARM_VALUE = 8'h55;
  localparam logic [7:0] TA_KEY1 = 8'haa;
  localparam logic [7:0] TA_KEY2 = 8'h55;
  localparam logic [7:0] ZONE_RESET = 8'hff;
  localparam logic [7:0] INFO_RESET = 8'h30;
  localparam logic [7:0] INFO_MASK = 8'h33;
  localparam int STAT_BIT = 0;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ = 100;
  localparam int UNLOCK_DELAY_MS = 300;
  localparam int UNLOCK_CYCLES = UNLOCK_DELAY_MS * 1000 * CLK_MHZ;
  localparam int CNT_W = 25;
  localparam logic [31:0] APB_OKAY_DATA = 32'h0000_0000;
  typedef enum logic [2:0] {
    TA_IDLE = 3'b001,
    TA_KEY = 3'b010,
    TA_OPEN = 3'b100
  } fpsc_ta_t;
endpackage

// ==== verilog/fpsc_timed_access.sv ====
module fpsc_timed_access import fpsc_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic wr_stb,
  input wire logic key_hit,
  input wire logic [7:0] wdata,
  output logic open
);
  fpsc_ta_t state, next_state;
  // ****************************************
  // Two key writes open one protected write
  // ****************************************
  always_comb begin
    next_state = state;
    case (state)
      TA_IDLE: if (wr_stb && key_hit && wdata == TA_KEY1) next_state = TA_KEY;
      TA_KEY: if (wr_stb) next_state = (key_hit && wdata == TA_KEY2) ? TA_OPEN : TA_IDLE;
      TA_OPEN: if (wr_stb) next_state = TA_IDLE; // Any write consumes the window
      default: next_state = TA_IDLE;
    endcase
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) state <= TA_IDLE;
    else state <= next_state;
  end
  assign open = (state == TA_OPEN);
endmodule // fpsc_timed_access

// ==== verilog/fpsc_top.sv ====
// Summary of operation
// - While protected, flash controller writes anywhere in 0x0000-0xFFFF are blocked, except in reset, where fc_wr_block resets to 0.
// - Every reset turns code protection on.
// - Writing 0x55 to the unlock register requests protection off.
// - Protection stays on until the 300 ms delay has run out.
// - Any other written value restores protection at once, cancelling pending unlock.
// - Status bit reads 1 when released, 0 while protected or waiting.
// - Writing 0x55 to the supply switch register sets the sleep-power-off flag.
// - Flag set and chip asleep switches the flash supply off.
// - Flag resets to 0; supply stays on in every mode then.
// - Zone bytes are read/write, eight bits each, reset to 0xff.
module fpsc_top import fpsc_pkg::*; #(
  parameter int DELAY_CYCLES = UNLOCK_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sleep_mode,
  input wire logic fc_wr_req,
  input wire logic [15:0] fc_wr_addr,
  output logic fc_wr_block,
  output logic flash_supply_on,
  output logic [23:0] zone_permanent_protect_bits,
  output logic [3:0] info_block_protect_bits,
  output logic code_protect_on
);
  // ****************************************
  // Bus decode
  // ****************************************
  logic access, wr_stb, rd_stb, ta_open, prot_wr, key_hit, mapped;
  logic timer_running, timer_done;
  logic [7:0] wbyte;
  assign access = psel && penable && pready;
  assign wr_stb = access && pwrite;
  assign rd_stb = access && !pwrite;
  assign wbyte = pwdata[7:0];
  assign key_hit = (paddr == ADDR_TA_KEY);
  assign prot_wr = wr_stb && ta_open;

  function automatic logic is_mapped(input logic [15:0] a);
    is_mapped = (a == ADDR_SUPPLY_SWITCH) || (a == ADDR_CODE_UNLOCK) || (a == ADDR_ZONE5) ||
                (a == ADDR_ZONE6) || (a == ADDR_ZONE7) || (a == ADDR_INFO_PROT) ||
                (a == ADDR_TA_KEY) || (a == ADDR_SLEEP_CTL);
  endfunction
  assign mapped = is_mapped(paddr);

  fpsc_timed_access u_ta (
    .clk(clk),
    .rst(rst),
    .wr_stb(wr_stb),
    .key_hit(key_hit),
    .wdata(wbyte),
    .open(ta_open)
  );

  // ****************************************
  // Unlock sequencing
  // ****************************************
  logic unlock_write, relock_write;
  assign unlock_write = prot_wr && paddr == ADDR_CODE_UNLOCK && wbyte == UNLOCK_VALUE;
  assign relock_write = prot_wr && paddr == ADDR_CODE_UNLOCK && wbyte != UNLOCK_VALUE;

  fpsc_delay_timer #(.DELAY_CYCLES(DELAY_CYCLES)) u_timer (
    .clk(clk),
    .rst(rst),
    .start(unlock_write),
    .cancel(relock_write),
    .running(timer_running),
    .done(timer_done)
  );

  // ****************************************
  // Register state
  // ****************************************
  logic released, next_released, sleep_flag, next_sleep_flag;
  logic [7:0] zone5, zone6, zone7, info_prot;
  logic [7:0] next_zone5, next_zone6, next_zone7, next_info_prot;

  // Release only on expiry; any keyed unlock-register write re-protects
  always_comb begin
    next_released = released;
    if (relock_write || unlock_write) next_released = 1'b0;
    else if (timer_done) next_released = 1'b1;
  end

  // Flag has no clear path except reset
  always_comb begin
    next_sleep_flag = sleep_flag;
    if (prot_wr && paddr == ADDR_SUPPLY_SWITCH && wbyte == ARM_VALUE) next_sleep_flag = 1'b1;
  end

  // Zone and information-block protect bytes
  always_comb begin
    next_zone5 = zone5;
    next_zone6 = zone6;
    next_zone7 = zone7;
    next_info_prot = info_prot;
    if (prot_wr) begin
      case (paddr)
        ADDR_ZONE5: next_zone5 = wbyte;
        ADDR_ZONE6: next_zone6 = wbyte;
        ADDR_ZONE7: next_zone7 = wbyte;
        ADDR_INFO_PROT: next_info_prot = wbyte & INFO_MASK;
        default: ;
      endcase
    end
  end

  // State registers; any reset re-protects and disarms
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      released <= 1'b0;
      sleep_flag <= 1'b0;
      zone5 <= ZONE_RESET;
      zone6 <= ZONE_RESET;
      zone7 <= ZONE_RESET;
      info_prot <= INFO_RESET;
    end else begin
      released <= next_released;
      sleep_flag <= next_sleep_flag;
      zone5 <= next_zone5;
      zone6 <= next_zone6;
      zone7 <= next_zone7;
      info_prot <= next_info_prot;
    end
  end

  // ****************************************
  // Bus answer and outputs
  // ****************************************
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr, next_fc_block, next_supply_on;

  // No wait state: pready rises the cycle after setup
  always_comb begin
    next_pready = psel && !pready;
    next_pslverr = psel && !pready && !mapped;
    next_prdata = APB_OKAY_DATA;
    if (psel && !pready && !pwrite) begin
      case (paddr)
        ADDR_CODE_UNLOCK: next_prdata[STAT_BIT] = next_released;
        ADDR_ZONE5: next_prdata[7:0] = zone5;
        ADDR_ZONE6: next_prdata[7:0] = zone6;
        ADDR_ZONE7: next_prdata[7:0] = zone7;
        ADDR_INFO_PROT: next_prdata[7:0] = info_prot;
        ADDR_SLEEP_CTL: next_prdata[0] = sleep_flag;
        default: next_prdata = APB_OKAY_DATA;
      endcase
    end
    // Full 16-bit space guarded; register rather than combinational for clean timing
    next_fc_block = fc_wr_req && !next_released;
    next_supply_on = !(next_sleep_flag && sleep_mode);
  end

  // Every output leaves a flip-flop
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata <= APB_OKAY_DATA;
      pready <= 1'b0;
      pslverr <= 1'b0;
      fc_wr_block <= 1'b0;
      flash_supply_on <= 1'b1;
      zone_permanent_protect_bits <= {ZONE_RESET, ZONE_RESET, ZONE_RESET};
      info_block_protect_bits <= {INFO_RESET[5:4], INFO_RESET[1:0]};
      code_protect_on <= 1'b1;
    end else begin
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      fc_wr_block <= next_fc_block;
      flash_supply_on <= next_supply_on;
      zone_permanent_protect_bits <= {next_zone7, next_zone6, next_zone5};
      info_block_protect_bits <= {next_info_prot[5:4], next_info_prot[1:0]};
      code_protect_on <= !next_released;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  sequence s_unlock;
    unlock_write;
  endsequence
  sequence s_quiet_wait;
    (!relock_write && !unlock_write) [*8];
  endsequence

  a_prot_after_unlock: assert property (@(posedge clk) disable iff (rst)
    s_unlock ##1 s_quiet_wait |-> code_protect_on) else $error("protection dropped early");
  a_relock_now: assert property (@(posedge clk) disable iff (rst)
    relock_write |=> code_protect_on && !released) else $error("relock not immediate");
  a_stat_match: assert property (@(posedge clk) disable iff (rst)
    rd_stb && paddr == ADDR_CODE_UNLOCK |-> prdata[STAT_BIT] == released) else $error("stat wrong");
  a_arm_flag: assert property (@(posedge clk) disable iff (rst)
    prot_wr && paddr == ADDR_SUPPLY_SWITCH && wbyte == ARM_VALUE |=> sleep_flag) else $error("flag not set");
  a_supply_off: assert property (@(posedge clk) disable iff (rst)
    sleep_flag && sleep_mode |=> !flash_supply_on) else $error("supply not off");
  a_supply_on: assert property (@(posedge clk) disable iff (rst)
    !$past(sleep_flag) && !sleep_flag |-> flash_supply_on) else $error("supply off unarmed");
  a_block_write: assert property (@(posedge clk) disable iff (rst)
    fc_wr_req && !next_released |=> fc_wr_block) else $error("write not blocked");
  a_zone_write: assert property (@(posedge clk) disable iff (rst)
    prot_wr && paddr == ADDR_ZONE5 |=> zone5 == $past(wbyte)) else $error("zone not stored");
  a_ta_guard: assert property (@(posedge clk) disable iff (rst)
    wr_stb && !ta_open && paddr == ADDR_ZONE6 |=> $stable(zone6)) else $error("unguarded write");
  a_restart: assert property (@(posedge clk) disable iff (rst)
    unlock_write |=> timer_running && !timer_done) else $error("timer not restarted");

  // ****************************************
  // Check helpers
  // ****************************************
  // Cycles since the last unlock write, cleared by a relock write; stops once the delay ends
  logic [CNT_W-1:0] since_unlock, next_since_unlock;

  // Counted apart from the timer so a wrong end point shows up
  always_comb begin
    next_since_unlock = since_unlock;
    if (unlock_write || relock_write) next_since_unlock = '0;
    else if (timer_running) next_since_unlock = since_unlock + 1'b1;
  end

  // Helper register; reset branch holds constants only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) since_unlock <= '0;
    else since_unlock <= next_since_unlock;
  end

  sequence s_relock;
    relock_write;
  endsequence

  // First edge after reset still protected
  a_reset_prot: assert property (@(posedge clk) disable iff (rst)
    $past(rst) |-> code_protect_on)
    else $error("protection off after reset");
  // No release while the delay runs
  a_hold_running: assert property (@(posedge clk) disable iff (rst)
    timer_running |-> code_protect_on)
    else $error("released during delay");
  // Expiry comes exactly the full delay after the last unlock write
  a_delay_length: assert property (@(posedge clk) disable iff (rst)
    timer_done |-> since_unlock == CNT_W'(DELAY_CYCLES))
    else $error("delay length wrong");
  // Expiry with no competing write releases
  a_release_expiry: assert property (@(posedge clk) disable iff (rst)
    timer_done && !relock_write && !unlock_write |=> !code_protect_on)
    else $error("no release on expiry");
  // Wrong value abandons a pending unlock
  a_relock_cancel: assert property (@(posedge clk) disable iff (rst)
    s_relock |=> !timer_running)
    else $error("pending unlock kept");
  // Status reads 0 while waiting
  a_stat_pending: assert property (@(posedge clk) disable iff (rst)
    rd_stb && paddr == ADDR_CODE_UNLOCK && timer_running |-> !prdata[STAT_BIT])
    else $error("stat set during delay");
  // Status reads 1 once released
  a_stat_released: assert property (@(posedge clk) disable iff (rst)
    rd_stb && paddr == ADDR_CODE_UNLOCK && !code_protect_on |-> prdata[STAT_BIT])
    else $error("stat clear when released");
  // Only reset clears the armed flag
  a_flag_sticky: assert property (@(posedge clk) disable iff (rst)
    sleep_flag |=> sleep_flag)
    else $error("flag cleared");
  // Awake chip always keeps the supply
  a_supply_awake: assert property (@(posedge clk) disable iff (rst)
    !sleep_mode |=> flash_supply_on)
    else $error("supply off while awake");
  // Upper zone byte reaches the output
  a_zone_upper: assert property (@(posedge clk) disable iff (rst)
    prot_wr && paddr == ADDR_ZONE7 |=> zone_permanent_protect_bits[23:16] == $past(wbyte))
    else $error("zone 7 not stored");
  // One opened window serves one write
  a_ta_single: assert property (@(posedge clk) disable iff (rst)
    ta_open && wr_stb |=> !ta_open)
    else $error("window left open");
  // Unkeyed arming write is ignored
  a_ta_supply_guard: assert property (@(posedge clk) disable iff (rst)
    wr_stb && !ta_open && paddr == ADDR_SUPPLY_SWITCH |=> $stable(sleep_flag))
    else $error("unguarded arm");
  // No request, no block
  a_block_idle: assert property (@(posedge clk) disable iff (rst)
    !fc_wr_req |=> !fc_wr_block)
    else $error("block without request");
  // Released space lets writes through
  a_block_open: assert property (@(posedge clk) disable iff (rst)
    fc_wr_req && !code_protect_on && !relock_write && !unlock_write |=> !fc_wr_block)
    else $error("write blocked when released");
  // Ready stands one cycle per access
  a_ready_pulse: assert property (@(posedge clk) disable iff (rst)
    pready |=> !pready)
    else $error("ready held");
  // Error only alongside ready
  a_err_with_ready: assert property (@(posedge clk) disable iff (rst)
    pslverr |-> pready)
    else $error("error without ready");
endmodule // fpsc_top
